// ### include/nibble_exec_pkg.sv
// Shared constants for the nibble instruction execute core.
// Assumes one synchronous clock domain; opcode patterns are casez items.
package nibble_exec_pkg;

   // Data path widths
   localparam int NIBBLE_W = 4;
   localparam int BYTE_W   = 8;
   localparam int DADDR_W  = 6;
   localparam int HIGH_W   = 2;

   // Values after reset
   localparam logic [3:0] ACC_RESET   = 4'h0;
   localparam logic [1:0] HIGH_RESET  = 2'h0;
   localparam logic [3:0] LOW_RESET   = 4'h0;
   localparam logic       CARRY_RESET = 1'b0;

   // Nibble step and boundary values used by increments, decrements and skip tests
   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam logic [3:0] NIB_ONE  = 4'h1;
   localparam logic [3:0] NIB_FULL = 4'hF;

   // Field positions inside an opcode byte
   localparam int IMM4_MSB  = 3;
   localparam int IMM5_TOP  = 4;
   localparam int DIRECT_MSB = 5;

   // Pair pointer mode encodings
   localparam logic [1:0] PAIR_DEC  = 2'h0;
   localparam logic [1:0] PAIR_INC  = 2'h1;
   localparam logic [1:0] PAIR_HOLD = 2'h2;

   // Opcode patterns, first byte
   localparam logic [7:0] OP_LOAD_ACC_IMM    = 8'b0001????;
   localparam logic [7:0] OP_LOAD_HIGH_IMM   = 8'b001010??;
   localparam logic [7:0] OP_LOAD_ACC_MEM    = 8'b010100??;
   localparam logic [7:0] OP_LOAD_PAIR_IMM   = 8'b110?????;
   localparam logic [7:0] OP_WRITE_ACC_MEM   = 8'h57;
   localparam logic [7:0] OP_STORE_IMM_INC   = 8'b0100????;
   localparam logic [7:0] OP_SWAP_ACC_LOW    = 8'h7B;
   localparam logic [7:0] OP_SWAP_ACC_MEM    = 8'b010101??;
   localparam logic [7:0] OP_ADD_IMM_SKIP    = 8'b0000????;
   localparam logic [7:0] OP_ADD_MEM_SKIP    = 8'h7D;
   localparam logic [7:0] OP_ADD_MEM_CARRY   = 8'h7C;
   localparam logic [7:0] OP_XOR_ACC_MEM     = 8'h7E;
   localparam logic [7:0] OP_INVERT_ACC      = 8'h7F;
   localparam logic [7:0] OP_CLEAR_CARRY     = 8'h78;
   localparam logic [7:0] OP_SET_CARRY       = 8'h79;
   localparam logic [7:0] OP_INC_LOW_SKIP    = 8'h59;
   localparam logic [7:0] OP_DEC_LOW_SKIP    = 8'h58;
   localparam logic [7:0] OP_CLEAR_MEM_BIT   = 8'b011010??;
   localparam logic [7:0] OP_SET_MEM_BIT     = 8'b011011??;
   localparam logic [7:0] OP_INC_DIRECT_SKIP = 8'h3D;
   localparam logic [7:0] OP_DEC_DIRECT_SKIP = 8'h3C;

   // Other two-byte opcodes, decoded only for their length
   localparam logic [7:0] OP_LONG_JUMP  = 8'b001000??;
   localparam logic [7:0] OP_LONG_CALL  = 8'b001100??;
   localparam logic [7:0] OP_LONG_STACK = 8'h3F;

   // Fetch state
   typedef enum logic [0:0] {
      FETCH_OPCODE  = 1'b0,
      FETCH_OPERAND = 1'b1
   } fetch_state_t;

   // Kind of instruction for run detection
   typedef enum logic [1:0] {
      RUN_NONE = 2'b00,
      RUN_ACC  = 2'b01,
      RUN_PAIR = 2'b10
   } run_kind_t;

endpackage

// ### design/nibble_adder.sv
// Four-bit adder with carry in and carry out.
// Assumes purely combinational use by the execute core.
module nibble_adder #(
   parameter int WIDTH = 4
) (
   // Operands
   input  wire logic [WIDTH-1:0] addend_a,
   input  wire logic [WIDTH-1:0] addend_b,
   input  wire logic             carry_in,
   // Result
   output logic      [WIDTH-1:0] sum,
   output logic                  carry_out
);

   logic [WIDTH:0] wide_sum;

   // One extra bit holds the carry out of the top position
   always_comb begin
      wide_sum  = {1'b0, addend_a} + {1'b0, addend_b} + {{WIDTH{1'b0}}, carry_in};
      sum       = wide_sum[WIDTH-1:0];
      carry_out = wide_sum[WIDTH];
   end

endmodule

// ### design/nibble_exec_core.sv
// Execute core for the load, arithmetic, increment and bit instructions
// of a four-bit controller, with its own nibble data memory.
// Assumes instruction bytes arrive in program order on a valid/ready
// handshake synchronous to clock; branch and I/O opcodes run as no-ops.

// Behaviour
// - Load four-bit immediate into accumulator, runs
// - Load two-bit immediate into high register
// - Load accumulator from pair memory, skip
// - Pair mode: decrement, increment or hold low
// - Load five-bit immediate into pair, runs
// - Write accumulator to memory at pair
// - Store immediate at pair, increment low
// - Swap accumulator with low register
// - Swap accumulator with pair memory, skip
// - Add immediate to accumulator, skip carry
// - Add memory to accumulator, skip carry
// - Xor, invert, clear and set carry
// - Increment low register, skip at zero
// - Increment direct memory, skip at zero
// - Direct memory operand is six bits
// - Decrement low register, skip at full
// - Decrement direct memory, skip at full
// - Clear selected bit of pair memory
// - Set selected bit of pair memory
module nibble_exec_core #(
   parameter int DATA_W  = 4,
   parameter int ADDR_W  = 6,
   parameter int DEPTH   = 64
) (
   // Clock, reset and enable
   input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              clock_enable,
   // Instruction bytes from program memory
   input  wire logic              byte_valid,
   input  wire logic [7:0]        byte_data,
   output logic                   byte_ready,
   // Visible processor state
   output logic [DATA_W-1:0]      acc,
   output logic [1:0]             high,
   output logic [DATA_W-1:0]      low,
   output logic                   carry,
   output logic                   skip_pending,
   // Completion pulses
   output logic                   exec_done,
   output logic                   skip_done
);

   // Registers
   nibble_exec_pkg::fetch_state_t state_reg;
   nibble_exec_pkg::run_kind_t    run_kind_reg;
   logic [DATA_W-1:0]             acc_reg;
   logic [1:0]                    high_reg;
   logic [DATA_W-1:0]             low_reg;
   logic                          carry_reg;
   logic                          skip_reg;
   logic                          hold_suppress_reg;
   logic [7:0]                    hold_op_reg;
   logic                          ready_reg;
   logic                          exec_done_reg;
   logic                          skip_done_reg;
   logic [DATA_W-1:0]             data_mem [DEPTH];

   // Decode and execute results
   nibble_exec_pkg::run_kind_t    run_kind_now;
   logic                          take;
   logic                          two_byte;
   logic                          finish;
   logic                          suppress;
   logic [7:0]                    op;
   logic [ADDR_W-1:0]             rd_addr;
   logic [DATA_W-1:0]             rd_data;
   logic [DATA_W-1:0]             add_b;
   logic                          add_cin;
   logic [DATA_W-1:0]             add_sum;
   logic                          add_cout;
   logic [DATA_W-1:0]             acc_next;
   logic [1:0]                    high_next;
   logic [DATA_W-1:0]             low_next;
   logic                          carry_next;
   logic                          cond_next;
   logic                          mem_we;
   logic [DATA_W-1:0]             mem_wdata;
   logic [DATA_W-1:0]             pair_low;
   logic                          pair_cond;
   logic [DATA_W-1:0]             direct_val;

   // A byte is taken only while enabled and ready
   assign take = clock_enable && ready_reg && byte_valid;

   // Opcode in force: held first byte while the operand arrives
   assign op = (state_reg == nibble_exec_pkg::FETCH_OPERAND) ? hold_op_reg : byte_data;

   // Length decode also covers opcodes this core leaves alone
   always_comb begin
      casez (byte_data)
         nibble_exec_pkg::OP_INC_DIRECT_SKIP,
         nibble_exec_pkg::OP_DEC_DIRECT_SKIP,
         nibble_exec_pkg::OP_LONG_STACK,
         nibble_exec_pkg::OP_LONG_JUMP,
         nibble_exec_pkg::OP_LONG_CALL: two_byte = 1'b1;
         default:                       two_byte = 1'b0;
      endcase
   end

   // Only immediate accumulator and pair loads form runs
   always_comb begin
      casez (byte_data)
         nibble_exec_pkg::OP_LOAD_ACC_IMM:  run_kind_now = nibble_exec_pkg::RUN_ACC;
         nibble_exec_pkg::OP_LOAD_PAIR_IMM: run_kind_now = nibble_exec_pkg::RUN_PAIR;
         default:                           run_kind_now = nibble_exec_pkg::RUN_NONE;
      endcase
   end

   // Instruction completes on its last byte
   assign finish = take && ((state_reg == nibble_exec_pkg::FETCH_OPERAND) || !two_byte);

   // Suppression is fixed at the opcode byte and held over the operand
   always_comb begin
      if (state_reg == nibble_exec_pkg::FETCH_OPERAND) begin
         suppress = hold_suppress_reg;
      end else begin
         suppress = skip_reg ||
                    (run_kind_now != nibble_exec_pkg::RUN_NONE && run_kind_now == run_kind_reg);
      end
   end

   // Memory is read at the pair, or at the direct operand
   always_comb begin
      if (state_reg == nibble_exec_pkg::FETCH_OPERAND) begin
         rd_addr = byte_data[nibble_exec_pkg::DIRECT_MSB:0];
      end else begin
         rd_addr = {high_reg, low_reg};
      end
   end
   assign rd_data = data_mem[rd_addr];

   // Adder operand: immediate for the immediate add, else memory
   always_comb begin
      casez (op)
         nibble_exec_pkg::OP_ADD_IMM_SKIP: add_b = op[nibble_exec_pkg::IMM4_MSB:0];
         default:                          add_b = rd_data;
      endcase
      add_cin = (op == nibble_exec_pkg::OP_ADD_MEM_CARRY) ? carry_reg : 1'b0;
   end

   nibble_adder #(
      .WIDTH     (DATA_W)
   ) adder (
      .addend_a  (acc_reg),
      .addend_b  (add_b),
      .carry_in  (add_cin),
      .sum       (add_sum),
      .carry_out (add_cout)
   );

   // Pair pointer post-update and its skip test
   always_comb begin
      case (op[1:0])
         nibble_exec_pkg::PAIR_DEC: begin
            pair_low  = low_reg - nibble_exec_pkg::NIB_ONE;
            pair_cond = (pair_low == nibble_exec_pkg::NIB_FULL);
         end
         nibble_exec_pkg::PAIR_INC: begin
            pair_low  = low_reg + nibble_exec_pkg::NIB_ONE;
            pair_cond = (pair_low == nibble_exec_pkg::NIB_ZERO);
         end
         default: begin
            pair_low  = low_reg;
            pair_cond = 1'b0;
         end
      endcase
   end

   // Direct memory step, up for increment and down otherwise
   assign direct_val = (hold_op_reg == nibble_exec_pkg::OP_INC_DIRECT_SKIP) ?
                       rd_data + nibble_exec_pkg::NIB_ONE : rd_data - nibble_exec_pkg::NIB_ONE;

   // Next state of every register for the instruction in hand
   always_comb begin
      acc_next   = acc_reg;
      high_next  = high_reg;
      low_next   = low_reg;
      carry_next = carry_reg;
      cond_next  = 1'b0;
      mem_we     = 1'b0;
      mem_wdata  = rd_data;
      if (state_reg == nibble_exec_pkg::FETCH_OPERAND) begin
         case (hold_op_reg)
            nibble_exec_pkg::OP_INC_DIRECT_SKIP: begin
               mem_we    = 1'b1;
               mem_wdata = direct_val;
               cond_next = (direct_val == nibble_exec_pkg::NIB_ZERO);
            end
            nibble_exec_pkg::OP_DEC_DIRECT_SKIP: begin
               mem_we    = 1'b1;
               mem_wdata = direct_val;
               cond_next = (direct_val == nibble_exec_pkg::NIB_FULL);
            end
            default: begin
               mem_we = 1'b0;
            end
         endcase
      end else begin
         casez (op)
            8'h53: mem_we = 1'b0; // Return shares the load pattern, left alone
            nibble_exec_pkg::OP_LOAD_ACC_IMM: begin
               acc_next = op[nibble_exec_pkg::IMM4_MSB:0];
            end
            nibble_exec_pkg::OP_LOAD_HIGH_IMM: begin
               high_next = op[1:0];
            end
            nibble_exec_pkg::OP_LOAD_ACC_MEM: begin
               acc_next  = rd_data;
               low_next  = pair_low;
               cond_next = pair_cond;
            end
            nibble_exec_pkg::OP_LOAD_PAIR_IMM: begin
               high_next = {1'b0, op[nibble_exec_pkg::IMM5_TOP]};
               low_next  = op[nibble_exec_pkg::IMM4_MSB:0];
            end
            nibble_exec_pkg::OP_WRITE_ACC_MEM: begin
               mem_we    = 1'b1;
               mem_wdata = acc_reg;
            end
            nibble_exec_pkg::OP_STORE_IMM_INC: begin
               mem_we    = 1'b1;
               mem_wdata = op[nibble_exec_pkg::IMM4_MSB:0];
               low_next  = low_reg + nibble_exec_pkg::NIB_ONE;
            end
            nibble_exec_pkg::OP_SWAP_ACC_LOW: begin
               acc_next = low_reg;
               low_next = acc_reg;
            end
            nibble_exec_pkg::OP_SWAP_ACC_MEM: begin
               acc_next  = rd_data;
               mem_we    = 1'b1;
               mem_wdata = acc_reg;
               low_next  = pair_low;
               cond_next = pair_cond;
            end
            nibble_exec_pkg::OP_ADD_IMM_SKIP,
            nibble_exec_pkg::OP_ADD_MEM_SKIP: begin
               acc_next  = add_sum;
               cond_next = add_cout;
            end
            nibble_exec_pkg::OP_ADD_MEM_CARRY: begin
               acc_next   = add_sum;
               carry_next = add_cout;
               cond_next  = add_cout;
            end
            nibble_exec_pkg::OP_XOR_ACC_MEM: begin
               acc_next = acc_reg ^ rd_data;
            end
            nibble_exec_pkg::OP_INVERT_ACC: begin
               acc_next = ~acc_reg;
            end
            nibble_exec_pkg::OP_CLEAR_CARRY: begin
               carry_next = 1'b0;
            end
            nibble_exec_pkg::OP_SET_CARRY: begin
               carry_next = 1'b1;
            end
            nibble_exec_pkg::OP_INC_LOW_SKIP: begin
               low_next  = low_reg + nibble_exec_pkg::NIB_ONE;
               cond_next = (low_next == nibble_exec_pkg::NIB_ZERO);
            end
            nibble_exec_pkg::OP_DEC_LOW_SKIP: begin
               low_next  = low_reg - nibble_exec_pkg::NIB_ONE;
               cond_next = (low_next == nibble_exec_pkg::NIB_FULL);
            end
            nibble_exec_pkg::OP_CLEAR_MEM_BIT: begin
               mem_we            = 1'b1;
               mem_wdata[op[1:0]] = 1'b0;
            end
            nibble_exec_pkg::OP_SET_MEM_BIT: begin
               mem_we            = 1'b1;
               mem_wdata[op[1:0]] = 1'b1;
            end
            default: begin
               mem_we = 1'b0;
            end
         endcase
      end
   end

   // Fetch sequencing; ready is low from reset until the first enabled clock after it
   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg         <= nibble_exec_pkg::FETCH_OPCODE;
         hold_op_reg       <= 8'h00;
         hold_suppress_reg <= 1'b0;
         ready_reg         <= 1'b0;
      end else if (clock_enable) begin
         ready_reg <= 1'b1;
         if (take && state_reg == nibble_exec_pkg::FETCH_OPCODE && two_byte) begin
            state_reg         <= nibble_exec_pkg::FETCH_OPERAND;
            hold_op_reg       <= byte_data;
            hold_suppress_reg <= suppress;
         end else if (finish) begin
            state_reg <= nibble_exec_pkg::FETCH_OPCODE;
         end
      end
   end

   // Run kind follows every opcode, executed or not, so a run stays a run
   always_ff @(posedge clock) begin
      if (reset) begin
         run_kind_reg <= nibble_exec_pkg::RUN_NONE;
      end else if (clock_enable && take && state_reg == nibble_exec_pkg::FETCH_OPCODE) begin
         run_kind_reg <= run_kind_now;
      end
   end

   // Architectural registers change only for an instruction not suppressed
   always_ff @(posedge clock) begin
      if (reset) begin
         acc_reg   <= nibble_exec_pkg::ACC_RESET;
         high_reg  <= nibble_exec_pkg::HIGH_RESET;
         low_reg   <= nibble_exec_pkg::LOW_RESET;
         carry_reg <= nibble_exec_pkg::CARRY_RESET;
      end else if (clock_enable && finish && !suppress) begin
         acc_reg   <= acc_next;
         high_reg  <= high_next;
         low_reg   <= low_next;
         carry_reg <= carry_next;
      end
   end

   // A suppressed instruction raises no new skip of its own
   always_ff @(posedge clock) begin
      if (reset) begin
         skip_reg <= 1'b0;
      end else if (clock_enable && finish) begin
         skip_reg <= !suppress && cond_next;
      end
   end

   // Data memory keeps its contents through reset
   always_ff @(posedge clock) begin
      if (clock_enable && finish && !suppress && mem_we) begin
         data_mem[rd_addr] <= mem_wdata;
      end
   end

   // One-cycle completion pulses
   always_ff @(posedge clock) begin
      if (reset) begin
         exec_done_reg <= 1'b0;
         skip_done_reg <= 1'b0;
      end else if (clock_enable) begin
         exec_done_reg <= finish && !suppress;
         skip_done_reg <= finish && suppress;
      end
   end

   // Outputs straight from registers
   assign byte_ready   = ready_reg;
   assign acc          = acc_reg;
   assign high         = high_reg;
   assign low          = low_reg;
   assign carry        = carry_reg;
   assign skip_pending = skip_reg;
   assign exec_done    = exec_done_reg;
   assign skip_done    = skip_done_reg;

endmodule

// ### test/nibble_exec_core_monitor.sv
// Port-level checker for the nibble execute core.
// Assumes one clock domain with synchronous active-high reset.
module nibble_exec_core_monitor (
   // Clock and control
   input wire logic       clock,
   input wire logic       reset,
   input wire logic       clock_enable,
   // Byte stream
   input wire logic       byte_valid,
   input wire logic [7:0] byte_data,
   input wire logic       byte_ready,
   // State and pulses
   input wire logic [3:0] acc,
   input wire logic [1:0] high,
   input wire logic [3:0] low,
   input wire logic       carry,
   input wire logic       skip_pending,
   input wire logic       exec_done,
   input wire logic       skip_done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   logic operand_reg;
   logic take;
   logic op_take;
   assign take    = clock_enable && byte_valid && byte_ready;
   assign op_take = take && !operand_reg;
   // Operand bytes must never be decoded as opcodes
   always_ff @(posedge clock) begin
      if (reset) begin
         operand_reg <= 1'b0;
      end else if (take) begin
         operand_reg <= !operand_reg && (byte_data inside {8'h3C, 8'h3D, 8'h3F} || byte_data[7:2] inside {6'h08, 6'h0C});
      end
   end
   property p_reset_state;
      $fell(reset) |-> !byte_ready && acc == 4'h0 && high == 2'h0 && low == 4'h0 && !carry && !skip_pending;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("state not cleared by reset");
   property p_one_pulse;
      !(exec_done && skip_done);
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("executed and suppressed at once");
   property p_skip_frozen;
      skip_done |-> $stable(acc) && $stable(high) && $stable(low) && $stable(carry) && !skip_pending;
   endproperty
   a_skip_frozen: assert property (p_skip_frozen) else $error("suppressed instruction changed state");
   property p_load_acc;
      (op_take && byte_data[7:4] == 4'h1) ##1 exec_done |-> acc == $past(byte_data[3:0]);
   endproperty
   a_load_acc: assert property (p_load_acc) else $error("immediate accumulator load wrong");
   property p_load_high;
      (op_take && byte_data[7:2] == 6'h0A) ##1 exec_done |-> high == $past(byte_data[1:0]);
   endproperty
   a_load_high: assert property (p_load_high) else $error("high register load wrong");
   property p_load_pair;
      (op_take && byte_data[7:5] == 3'h6) ##1 exec_done |-> high == {1'b0, $past(byte_data[4])}
         && low == $past(byte_data[3:0]);
   endproperty
   a_load_pair: assert property (p_load_pair) else $error("pair load wrong");
   property p_swap_low;
      (op_take && byte_data == 8'h7B) ##1 exec_done |-> acc == $past(low) && low == $past(acc);
   endproperty
   a_swap_low: assert property (p_swap_low) else $error("accumulator and low swap wrong");
   property p_add_imm;
      (op_take && byte_data[7:4] == 4'h0) ##1 exec_done |->
         {skip_pending, acc} == 5'($past(acc)) + 5'($past(byte_data[3:0]));
   endproperty
   a_add_imm: assert property (p_add_imm) else $error("immediate add or carry skip wrong");
   property p_carry_ops;
      (op_take && byte_data[7:1] == 7'h3C) ##1 exec_done |-> carry == $past(byte_data[0]);
   endproperty
   a_carry_ops: assert property (p_carry_ops) else $error("carry clear or set wrong");
   property p_invert;
      (op_take && byte_data == 8'h7F) ##1 exec_done |-> acc == ~$past(acc);
   endproperty
   a_invert: assert property (p_invert) else $error("accumulator invert wrong");
   property p_inc_low;
      (op_take && byte_data == 8'h59) ##1 exec_done |-> low == 4'($past(low) + 4'h1) && skip_pending == (low == 4'h0);
   endproperty
   a_inc_low: assert property (p_inc_low) else $error("low increment or skip wrong");
   property p_dec_low;
      (op_take && byte_data == 8'h58) ##1 exec_done |-> low == 4'($past(low) - 4'h1) && skip_pending == (low == 4'hF);
   endproperty
   a_dec_low: assert property (p_dec_low) else $error("low decrement or skip wrong");
   // Main scenarios seen at least once
   c_skip_done: cover property (skip_pending ##1 skip_done);
   c_run_skip: cover property ((op_take && byte_data[7:4] == 4'h1) ##1 (op_take && byte_data[7:4] == 4'h1));
   c_carry_skip: cover property ((op_take && byte_data == 8'h7C) ##1 (exec_done && skip_pending));
endmodule

bind nibble_exec_core nibble_exec_core_monitor i_nibble_exec_core_monitor (.clock, .reset, .clock_enable,
   .byte_valid, .byte_data, .byte_ready, .acc, .high, .low, .carry, .skip_pending, .exec_done, .skip_done);

// ### test/prog_model.sv
// Program memory model feeding instruction bytes on valid/ready.
// Assumes the bench loads the bytes and pulses start once per run.
module prog_model (
   // Clock and handshake
   input  wire logic       clock,
   input  wire logic       clock_enable,
   input  wire logic       byte_ready,
   output logic            byte_valid,
   output logic [7:0]      byte_data,
   // Run control from the bench
   input  wire logic       start,
   input  wire logic       stall,
   input  var  int         count,
   input  wire logic [7:0] prog [0:31],
   output logic            done
);
   timeunit 1ns;
   timeprecision 1ps;
   int   idx;
   logic took;
   logic go;
   logic gap;
   initial begin
      byte_valid = 1'b0;
      byte_data  = 8'h00;
      idx        = 0;
      gap        = 1'b0;
      done       = 1'b1;
   end
   // Sample at the edge, change 1 ns later; a byte stands until taken
   always @(posedge clock) begin
      took = byte_valid && byte_ready && clock_enable;
      go   = start;
      #1;
      gap = 1'b0;
      if (go) begin
         idx = 0;
      end else if (took) begin
         idx = idx + 1;
         gap = stall;
      end
      done = idx >= count;
      if (!done && !gap) begin
         byte_valid = 1'b1;
         byte_data  = prog[idx];
      end else begin
         // Idle line toggles so a stale byte is never mistaken for data
         byte_valid = 1'b0;
         byte_data  = ~byte_data;
      end
   end
endmodule

// ### test/nibble_exec_core_test.sv
// Self-checking bench for the nibble execute core and its program feed.
// Assumes the checker is bound in; memory is read back through the accumulator.
module nibble_exec_core_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock, reset, clock_enable, byte_valid, byte_ready, carry, skip_pending;
   logic       exec_done, skip_done, start, stall, done;
   logic [7:0] byte_data;
   logic [3:0] acc, low;
   logic [1:0] high;
   logic [7:0] prog [0:31];
   logic [7:0] q [$];
   int         count, error_cnt, n_checks;
   logic [3:0] n_skip;

   prog_model i_prog_model (.clock(clock), .clock_enable(clock_enable), .byte_ready(byte_ready),
      .byte_valid(byte_valid), .byte_data(byte_data), .start(start), .stall(stall), .count(count),
      .prog(prog), .done(done));
   nibble_exec_core i_nibble_exec_core (.clock(clock), .reset(reset), .clock_enable(clock_enable),
      .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready), .acc(acc), .high(high),
      .low(low), .carry(carry), .skip_pending(skip_pending), .exec_done(exec_done), .skip_done(skip_done));

   // 40 MHz clock
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic complete_run();
      if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Hand the queued bytes to the feed and wait, bounded, until all are taken
   task automatic run();
      int i;
      for (i = 0; i < q.size(); i++) prog[i] = q[i];
      count = q.size();
      n_skip = 4'h0;
      start = 1'b1;
      @(posedge clock);
      #2 start = 1'b0;
      for (i = 0; i < 200; i++) begin
         @(posedge clock);
         #2;
         n_skip = n_skip + {3'h0, skip_done};
         if (done) break;
      end
      if (!done) begin
         error_cnt++;
         complete_run();
      end
   endtask

   // Second load of a run is dropped
   task automatic t_load();
      q = '{8'h12, 8'h13, 8'hD3, 8'hD7, 8'h2B};
      run();
      check("acc", acc, 4'h2);
      check("low", low, 4'h3);
      check("high", {2'h0, high}, 4'h3);
      check("skips", n_skip, 4'h2);
   endtask

   task automatic t_store();
      q = '{8'hC4, 8'h4A, 8'h4B, 8'h17, 8'h57};
      run();
      check("acc", acc, 4'h7);
      check("low", low, 4'h6);
      q = '{8'hC4, 8'h51};
      run();
      check("acc", acc, 4'hA);
      check("low", low, 4'h5);
      q = '{8'h51, 8'h52};
      run();
      check("acc", acc, 4'h7);
      check("low", low, 4'h6);
   endtask

   // Swap with post-decrement wraps L and drops the next opcode
   task automatic t_swap();
      q = '{8'hC0, 8'h45, 8'h58, 8'h19, 8'h54, 8'h7F};
      run();
      check("acc", acc, 4'h5);
      check("low", low, 4'hF);
      check("skip", {3'h0, skip_pending}, 4'h0);
      check("skips", n_skip, 4'h1);
      q = '{8'hC0, 8'h52, 8'h7B};
      run();
      check("acc", acc, 4'h0);
      check("low", low, 4'h9);
   endtask

   // Arithmetic with a stalling feed
   task automatic t_arith();
      stall = 1'b1;
      q = '{8'hC0, 8'h46, 8'hC0, 8'h1C, 8'h05, 8'h7F};
      run();
      check("acc", acc, 4'h1);
      q = '{8'h7D, 8'h79, 8'h7C};
      run();
      check("acc", acc, 4'hE);
      check("carry", {3'h0, carry}, 4'h0);
      q = '{8'h7C, 8'h7F};
      run();
      check("acc", acc, 4'h4);
      check("carry", {3'h0, carry}, 4'h1);
      q = '{8'h7E, 8'h7F, 8'h78};
      run();
      check("acc", acc, 4'hD);
      check("carry", {3'h0, carry}, 4'h0);
      stall = 1'b0;
   endtask

   // Counts across the wrap boundaries, direct operand bits 5:4 select the page
   task automatic t_incdec();
      q = '{8'h58, 8'h7F, 8'h59, 8'h7F};
      run();
      check("low", low, 4'h0);
      check("acc", acc, 4'hD);
      check("skips", n_skip, 4'h2);
      q = '{8'hC3, 8'h4F, 8'h3D, 8'h03, 8'h7F, 8'hC3, 8'h52};
      run();
      check("acc", acc, 4'h0);
      q = '{8'h3C, 8'hC3, 8'h7F, 8'h52};
      run();
      check("acc", acc, 4'hF);
      q = '{8'hC3, 8'h2A, 8'h45, 8'h3C, 8'h23, 8'h58, 8'h52};
      run();
      check("acc", acc, 4'h4);
      check("high", {2'h0, high}, 4'h2);
   endtask

   task automatic t_bits();
      q = '{8'hC7, 8'h4A, 8'h58, 8'h69, 8'h6E, 8'h52};
      run();
      check("acc", acc, 4'hC);
   endtask

   initial begin
      reset        = 1'b1;
      clock_enable = 1'b1;
      start        = 1'b0;
      stall        = 1'b0;
      count        = 0;
      error_cnt    = 0;
      n_checks     = 0;
      repeat (3) @(posedge clock);
      #2 reset = 1'b0;
      check("ready", {3'h0, byte_ready}, 4'h0);
      check("acc", acc, 4'h0);
      check("low", low, 4'h0);
      t_load();
      t_store();
      t_swap();
      t_arith();
      t_incdec();
      t_bits();
      complete_run();
   end
endmodule
